// file: core/flash_program_erase_control.sv
// Flash program/erase sequencer with key lock, block staging and page lock
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_program_erase_control #(
  parameter int AW = 15,
  parameter int PROG_CYCLES = `FC_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FC_ERASE_CYCLES,
  parameter logic [AW-1:0] LOCK_ADDR = `FC_LOCK_ADDR
) (
  input wire logic mclk_i, // 20 MHz system clock
  input wire logic rst_n_i, // Async system reset, active low
  input wire logic xwr_i, // External data write strobe, one cycle
  input wire logic xrd_i, // External data read strobe, one cycle
  input wire logic [AW-1:0] xaddr_i, // External data address
  input wire logic [7:0] xdata_i, // External data write byte
  input wire logic key_wr_i, // Write to flash_key_register
  input wire logic [7:0] key_data_i, // Key value
  input wire logic program_store_write_enable_i, // Control bit 0
  input wire logic program_store_erase_enable_i, // Control bit 1
  input wire logic block_write_select_i, // Block mode select
  input wire logic supply_monitor_ok_i, // Supply monitor and reset on
  input wire logic debug_port_i, // Request comes from debug port
  input wire logic code_protected_i, // Code runs from a locked page
  input wire logic [7:0] lock_byte_i, // Lock byte sampled at reset
  input wire logic [7:0] flash_rdata_i, // Current array byte at address
  output logic xram_wr_o, // Write passed to data RAM
  output logic xram_rd_o, // Read passed to data RAM
  output logic [AW-1:0] xram_addr_o, // Data RAM address
  output logic [7:0] xram_wdata_o, // Data RAM write byte
  output logic fl_wr_o, // Array byte write pulse
  output logic [AW-1:0] fl_addr_o, // Array address
  output logic [7:0] fl_wdata_o, // Array write byte
  output logic fl_page_erase_o, // Array page erase pulse
  output logic flash_busy_flag_o, // Timed operation in progress
  output logic fetch_stall_o, // Stall flash instruction fetch
  output logic flash_error_reset_o, // Flash-error device reset request
  output logic key_disabled_o // Key lock dead until reset
);
  flash_ctrl_pkg::key_state_e key_reg, key_next;
  flash_ctrl_pkg::op_state_e op_reg;
  logic [7:0] stage_reg [4];
  logic [1:0] pos_reg;
  logic [7:0] lock_reg;
  logic lock_valid_reg;
  logic [AW-1:0] op_addr_reg;
  logic op_blk_reg;
  logic burst_reg;
  logic [2:0] step_reg;
  logic op_done;
  logic tmr_start;
  logic [19:0] tmr_load;

  // Decode of incoming write
  // Write-enable is a level that software owns; nothing here clears it
  wire to_flash = xwr_i && program_store_write_enable_i;
  wire erase_req = to_flash && program_store_erase_enable_i;
  wire prog_req = to_flash && !program_store_erase_enable_i;
  wire unlocked = (key_reg == flash_ctrl_pkg::KEY_OPEN);
  wire idle = (op_reg == flash_ctrl_pkg::OP_IDLE);
  // Page lock: count of pages from page 0 plus the lock-byte page
  wire [7:0] n_locked = ~lock_reg;
  wire [AW-1:0] page_no = AW'(xaddr_i >> `FC_PAGE_BITS);
  wire lock_page_hit = (page_no == AW'(LOCK_ADDR >> `FC_PAGE_BITS));
  wire any_locked = (lock_reg != `FC_ERASED_BYTE);
  wire in_locked = (page_no < AW'(n_locked)) || (lock_page_hit && any_locked);
  wire untrusted = debug_port_i || !code_protected_i;
  wire refused = in_locked && untrusted;
  // Debug-port refusals are quiet; firmware refusals reset the device
  wire fatal = to_flash && ((!supply_monitor_ok_i) ||
    (refused && !debug_port_i) || !unlocked);
  wire accept = to_flash && idle && unlocked && supply_monitor_ok_i &&
    !refused;
  wire blk_last = (xaddr_i[1:0] == `FC_BLOCK_LAST);
  wire blk_step = prog_req && accept && block_write_select_i;
  wire blk_in_order = (xaddr_i[1:0] == pos_reg);
  wire start_prog = prog_req && accept &&
    (!block_write_select_i || (blk_last && blk_in_order));
  wire start_erase = erase_req && accept;
  // End of a timed program; a block program then runs a write burst
  wire prog_end = op_done && (op_reg == flash_ctrl_pkg::OP_PROGRAM);
  wire burst_go = prog_end && op_blk_reg;
  wire burst_last = burst_reg && (step_reg == 3'h6);
  wire op_end = (op_done && !burst_go) || burst_last;
  wire [2:0] step_up = step_reg + 3'h1;
  // Bytes leave on alternate cycles so each merge reads a settled address
  wire [1:0] blk_idx = step_up[2:1];
  wire byte_pulse = prog_end || (burst_reg && !step_reg[0]);

  // Key sequencer
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      flash_ctrl_pkg::KEY_LOCKED:
        if (key_wr_i) key_next = (key_data_i == `FC_KEY_FIRST) ?
          flash_ctrl_pkg::KEY_HALF : flash_ctrl_pkg::KEY_DEAD;
      flash_ctrl_pkg::KEY_HALF:
        if (key_wr_i) key_next = (key_data_i == `FC_KEY_SECOND) ?
          flash_ctrl_pkg::KEY_OPEN : flash_ctrl_pkg::KEY_DEAD;
      flash_ctrl_pkg::KEY_OPEN:
        if (key_wr_i) key_next = flash_ctrl_pkg::KEY_DEAD;
        else if (to_flash && !accept) key_next = flash_ctrl_pkg::KEY_DEAD;
        else if (to_flash) key_next = flash_ctrl_pkg::KEY_LOCKED;
      flash_ctrl_pkg::KEY_DEAD: key_next = flash_ctrl_pkg::KEY_DEAD;
      default: key_next = flash_ctrl_pkg::KEY_DEAD;
    endcase
    if (to_flash && key_reg != flash_ctrl_pkg::KEY_OPEN)
      key_next = flash_ctrl_pkg::KEY_DEAD;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) key_reg <= flash_ctrl_pkg::KEY_LOCKED;
    else key_reg <= key_next;
  end

  // Lock byte captured on the first clock after reset release
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_reg <= `FC_ERASED_BYTE;
      lock_valid_reg <= 1'b0;
    end else if (!lock_valid_reg) begin
      lock_reg <= lock_byte_i;
      lock_valid_reg <= 1'b1;
    end
  end

  // Block staging; a write to the lock byte only acts after the next reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_reg <= 2'h0;
      for (int i = 0; i < 4; i++) stage_reg[i] <= `FC_ERASED_BYTE;
    end else if (!block_write_select_i) begin
      pos_reg <= 2'h0;
      for (int i = 0; i < 4; i++) stage_reg[i] <= `FC_ERASED_BYTE;
    end else if (blk_step) begin
      stage_reg[xaddr_i[1:0]] <= xdata_i;
      pos_reg <= blk_in_order ? pos_reg + 2'h1 : 2'h0;
    end else if (burst_last) begin
      for (int i = 0; i < 4; i++) stage_reg[i] <= `FC_ERASED_BYTE;
    end
  end

  // Timed operation: one timer length shared by byte and block programs
  assign tmr_start = start_prog || start_erase;
  assign tmr_load = start_erase ? 20'(ERASE_CYCLES) : 20'(PROG_CYCLES);

  flash_op_timer #(.CW(20)) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .done_o(op_done)
  );

  // Operation state; the block flag is held for the whole operation
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg <= flash_ctrl_pkg::OP_IDLE;
      op_addr_reg <= '0;
      op_blk_reg <= 1'b0;
    end else if (start_erase) begin
      op_reg <= flash_ctrl_pkg::OP_ERASE;
      op_addr_reg <= xaddr_i;
      op_blk_reg <= 1'b0;
    end else if (start_prog) begin
      op_reg <= flash_ctrl_pkg::OP_PROGRAM;
      op_addr_reg <= xaddr_i;
      op_blk_reg <= block_write_select_i;
    end else if (op_end) begin
      op_reg <= flash_ctrl_pkg::OP_IDLE;
    end
  end

  // Burst step counter, running only after a block program's timed wait
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_reg <= 1'b0;
      step_reg <= 3'h0;
    end else if (burst_go) begin
      burst_reg <= 1'b1;
      step_reg <= 3'h1;
    end else if (burst_last) begin
      burst_reg <= 1'b0;
      step_reg <= 3'h0;
    end else if (burst_reg) begin
      step_reg <= step_up;
    end
  end

  // Byte to program and where it goes; merged with the old cell below
  logic [7:0] prog_data_reg;
  wire [7:0] new_byte = op_blk_reg ? stage_reg[blk_idx] : prog_data_reg;
  wire [AW-1:0] prog_addr = op_blk_reg ?
    {op_addr_reg[AW-1:2], blk_idx} : op_addr_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) prog_data_reg <= `FC_ERASED_BYTE;
    else if (start_prog) prog_data_reg <= xdata_i;
  end

  // Output registers; data RAM path and array strobes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xram_wr_o <= 1'b0;
      xram_rd_o <= 1'b0;
      xram_addr_o <= '0;
      xram_wdata_o <= 8'h00;
      fl_wr_o <= 1'b0;
      fl_addr_o <= '0;
      fl_wdata_o <= `FC_ERASED_BYTE;
      fl_page_erase_o <= 1'b0;
      flash_busy_flag_o <= 1'b0;
      fetch_stall_o <= 1'b0;
      flash_error_reset_o <= 1'b0;
      key_disabled_o <= 1'b0;
    end else begin
      xram_wr_o <= xwr_i && !program_store_write_enable_i;
      xram_rd_o <= xrd_i;
      xram_addr_o <= xaddr_i;
      xram_wdata_o <= xdata_i;
      fl_page_erase_o <= op_done && op_reg == flash_ctrl_pkg::OP_ERASE;
      fl_wr_o <= byte_pulse;
      fl_addr_o <= (op_reg == flash_ctrl_pkg::OP_ERASE) ?
        {op_addr_reg[AW-1:`FC_PAGE_BITS], {`FC_PAGE_BITS{1'b0}}} :
        prog_addr;
      fl_wdata_o <= flash_rdata_i & new_byte;
      flash_busy_flag_o <= tmr_start || (!idle && !op_end);
      fetch_stall_o <= tmr_start || (!idle && !op_end);
      if (fatal && !flash_error_reset_o) flash_error_reset_o <= 1'b1;
      key_disabled_o <= (key_next == flash_ctrl_pkg::KEY_DEAD);
    end
  end

  // Checks
  AST_RAM_GATED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    xwr_i && program_store_write_enable_i |=> !xram_wr_o)
    else $error("write reached data RAM while write-enable set");
  AST_READ_RAM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    xrd_i |=> xram_rd_o)
    else $error("read not passed to data RAM");
  AST_BUSY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tmr_start |=> flash_busy_flag_o [*8])
    else $error("busy flag dropped early");
  AST_KEY_DEAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    key_reg == flash_ctrl_pkg::KEY_LOCKED && key_wr_i &&
    key_data_i != `FC_KEY_FIRST |=> key_reg == flash_ctrl_pkg::KEY_DEAD)
    else $error("bad key did not disable");
  AST_REARM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    accept |=> key_reg == flash_ctrl_pkg::KEY_LOCKED)
    else $error("key lock not re-armed");
  AST_NO_SUPPLY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    to_flash && !supply_monitor_ok_i |=> flash_error_reset_o && idle)
    else $error("modify without supply monitor");
  AST_BLOCK_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    blk_step && !blk_last |=> idle)
    else $error("block programmed before last byte");
  AST_STAGE_CLR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !block_write_select_i |=> pos_reg == 2'h0)
    else $error("staging not cleared");
  AST_REFUSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    to_flash && refused |=> idle)
    else $error("locked page modified");
  COV_ERASE: cover property (@(posedge mclk_i) start_erase);
  COV_BYTE: cover property (@(posedge mclk_i)
    start_prog && !block_write_select_i);
  COV_BLOCK: cover property (@(posedge mclk_i)
    start_prog && block_write_select_i);
  COV_DEAD: cover property (@(posedge mclk_i) key_disabled_o);
endmodule : flash_program_erase_control
`default_nettype wire

// file: core/flash_ctrl_defines.svh
// Constants for the flash program/erase controller
// Behaviour
// - Write-enable set routes external data writes to flash, not data RAM.
// - Write-enable stays set after an operation until software clears it.
// - Byte programming only clears bits; stored value is old AND new.
// - Flash is 1024-byte pages; erase sets a whole page to 0xff.
// - Erase and write enables set: any write erases its page, data ignored.
// - Erase needs both enables; any modification needs write-enable.
// - Block select 0 programs single bytes; 1 groups writes in four-byte blocks.
// - Single-byte mode starts programming after every flash-directed write.
// - Block programming takes the same time as single-byte programming.
// - Block bytes are held; programming starts after the write to 11b.
// - External data reads always go to data RAM; flash read by code reads.
// - Last user byte is the lock byte; its complement counts locked pages.
// - Lock-byte page is locked when any lock-byte bit is zero.
// - Locked pages refused to debug port and to unprotected code.
// - Wrong or out-of-order keys disable writes and erases until reset.
// - Key lock re-arms after every completed write or erase.
// - Busy flag is one during timed operations; core fetches stall.
// - Modify attempt with supply monitor off causes flash-error reset.
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH
`define FC_KEY_FIRST 8'ha5
`define FC_KEY_SECOND 8'hf1
`define FC_ERASED_BYTE 8'hff
`define FC_PAGE_BITS 10
`define FC_BLOCK_LAST 2'h3
`define FC_LOCK_ADDR 15'h7bff
`define FC_PROG_TIME_NS 40000
`define FC_ERASE_TIME_NS 20000000
`define FC_CLK_PERIOD_NS 50
`define FC_PROG_CYCLES ((`FC_PROG_TIME_NS + `FC_CLK_PERIOD_NS - 1) / `FC_CLK_PERIOD_NS)
`define FC_ERASE_CYCLES ((`FC_ERASE_TIME_NS + `FC_CLK_PERIOD_NS - 1) / `FC_CLK_PERIOD_NS)
`endif

// file: core/flash_ctrl_pkg.sv
// Types for the flash program/erase controller
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN,
    KEY_DEAD
  } key_state_e;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE
  } op_state_e;
endpackage : flash_ctrl_pkg

// file: core/flash_op_timer.sv
// Down-counter that times one flash program or erase operation
`timescale 1ns/100ps
`default_nettype none
module flash_op_timer #(
  parameter int CW = 20
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic start_i, // Load a new count
  input wire logic [CW-1:0] load_i, // Cycles the operation lasts
  output logic done_o // One-cycle pulse at the end
);
  logic [CW-1:0] cnt_reg;
  logic run_reg;
  wire last = run_reg && (cnt_reg == {{(CW-1){1'b0}}, 1'b1});

  // Count down; a start while running is never issued by the owner
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last;
      if (start_i) begin
        cnt_reg <= load_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 1'b1;
        if (last) run_reg <= 1'b0;
      end
    end
  end
endmodule : flash_op_timer
`default_nettype wire

// file: testbench/flash_array_model.sv
// Behavioural flash array that sits behind the controller's array port
`timescale 1ns/100ps
`default_nettype none
module flash_array_model #(
  parameter int AW = 15
) (
  input wire logic mclk_i, // System clock
  input wire logic wr_i, // Byte write pulse
  input wire logic erase_i, // Page erase pulse
  input wire logic [AW-1:0] addr_i, // Write or erase address
  input wire logic [7:0] wdata_i, // Byte to store
  input wire logic [AW-1:0] rd_addr_i, // Read address
  output logic [7:0] rdata_o // Stored byte at rd_addr_i
);
  logic [7:0] mem [0:(1<<AW)-1];
  // Array starts erased, as a blank part would
  initial begin
    for (int k = 0; k < (1 << AW); k++) begin
      mem[k] = 8'hff;
    end
  end
  // Combinational read, so the controller sees the byte it merges with
  assign rdata_o = mem[rd_addr_i];
  // Cells only lose ones on a write; the AND keeps the model no kinder
  always @(posedge mclk_i) begin
    if (wr_i) begin
      mem[addr_i] <= mem[addr_i] & wdata_i;
    end
    if (erase_i) begin
      for (int k = 0; k < 1024; k++) begin
        mem[{addr_i[AW-1:10], 10'(k)}] <= 8'hff;
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// file: testbench/flash_program_erase_control_test.sv
// Random and directed checks of the flash program/erase controller
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control_test;
  localparam int AW = 15;
  localparam int PROG = 8;
  localparam int ERASE = 16;
  logic mclk_i, rst_n_i, xwr_i, xrd_i, key_wr_i, program_store_write_enable, program_store_erase_enable, blk, sup_ok;
  logic dbg, prot, xram_wr, xram_rd, fl_wr, fl_erase, busy, stall, err, kdead;
  logic [AW-1:0] xaddr_i, xram_addr, fl_addr, a, a0;
  logic [7:0] xdata_i, key_data_i, lock_byte, rdata, xram_wdata, fl_wdata, d;
  logic [7:0] shadow [0:(1<<AW)-1];
  logic [7:0] blkd [4];
  int miscompares, check_count, seed, cycles, n, n_byte;

  flash_program_erase_control #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE))
  u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .xwr_i(xwr_i), .xrd_i(xrd_i),
    .xaddr_i(xaddr_i), .xdata_i(xdata_i), .key_wr_i(key_wr_i),
    .key_data_i(key_data_i), .program_store_write_enable_i(program_store_write_enable),
    .program_store_erase_enable_i(program_store_erase_enable), .block_write_select_i(blk),
    .supply_monitor_ok_i(sup_ok), .debug_port_i(dbg),
    .code_protected_i(prot), .lock_byte_i(lock_byte), .flash_rdata_i(rdata),
    .xram_wr_o(xram_wr), .xram_rd_o(xram_rd), .xram_addr_o(xram_addr),
    .xram_wdata_o(xram_wdata), .fl_wr_o(fl_wr), .fl_addr_o(fl_addr),
    .fl_wdata_o(fl_wdata), .fl_page_erase_o(fl_erase),
    .flash_busy_flag_o(busy), .fetch_stall_o(stall),
    .flash_error_reset_o(err), .key_disabled_o(kdead));

  flash_array_model #(.AW(AW)) u_array (.mclk_i(mclk_i), .wr_i(fl_wr),
    .erase_i(fl_erase), .addr_i(fl_addr), .wdata_i(fl_wdata),
    .rd_addr_i(busy ? fl_addr : xaddr_i), .rdata_o(rdata));

  // 20 MHz clock and a hang guard well above the expected run
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Expected merge of an old cell with a programmed byte
  function automatic logic [7:0] exp_prog(input logic [7:0] o, nw);
    return o & nw;
  endfunction : exp_prog
  // Random address in a page that no lock setting here covers
  function automatic logic [AW-1:0] rnd_addr();
    return {5'(2 + $unsigned($random(seed)) % 28), 10'($random(seed))};
  endfunction : rnd_addr

  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (exp !== got) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic reset_dut(input logic [7:0] lb);
    rst_n_i = 1'b0;
    lock_byte = lb;
    sup_ok = 1'b1;
    repeat (5) tick();
    rst_n_i = 1'b1;
    repeat (2) tick();
  endtask : reset_dut
  task automatic key(input logic [7:0] v);
    key_wr_i = 1'b1;
    key_data_i = v;
    tick();
    key_wr_i = 1'b0;
  endtask : key
  // Bare flash-directed write, write-enable raised only around it
  task automatic mw(input logic [AW-1:0] ad, input logic [7:0] dt);
    program_store_write_enable = 1'b1;
    xwr_i = 1'b1;
    xaddr_i = ad;
    xdata_i = dt;
    tick();
    xwr_i = 1'b0;
    program_store_write_enable = 1'b0;
  endtask : mw
  // Unlock before every byte; strobe held across both keys so it never
  // drops and rises in one step; erase-enable stays as the caller set it
  task automatic fw(input logic [AW-1:0] ad, input logic [7:0] dt);
    key_wr_i = 1'b1;
    key_data_i = 8'ha5;
    tick();
    key_data_i = 8'hf1;
    tick();
    key_wr_i = 1'b0;
    mw(ad, dt);
  endtask : fw
  task automatic wait_op(input int lim);
    n = 0;
    while (fl_wr !== 1'b1 && fl_erase !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask : wait_op
  task automatic prog(input logic [AW-1:0] ad, input logic [7:0] dt);
    fw(ad, dt);
    chk("xram_wr_o", 0, xram_wr);
    chk("busy stall", 2'b11, {busy, stall});
    wait_op(ERASE + 4);
    chk("fl_wr_o", {1'b1, ad}, {fl_wr, fl_addr});
  endtask : prog

  // Main sequence
  initial begin
    seed = 75;
    {xwr_i, xrd_i, key_wr_i, program_store_write_enable, program_store_erase_enable, blk, dbg, prot} = '0;
    xaddr_i = '0;
    xdata_i = '0;
    key_data_i = '0;
    for (int k = 0; k < (1 << AW); k++) shadow[k] = 8'hff;
    reset_dut(8'hfd);
    chk("fl_wdata_o", 8'hff, fl_wdata);
    chk("idle outputs", 0, {busy, stall, err, kdead, xram_wr, fl_wr});
    // Erase bit alone must not steer writes away from data RAM
    a = rnd_addr();
    d = 8'($random(seed));
    program_store_erase_enable = 1'b1;
    xwr_i = 1'b1;
    xaddr_i = a;
    xdata_i = d;
    tick();
    {xwr_i, program_store_erase_enable, program_store_write_enable, xrd_i} = 4'b0011;
    chk("xram_wr_o", 1, xram_wr);
    chk("xram write", {a, d}, {xram_addr, xram_wdata});
    tick();
    {xrd_i, program_store_write_enable} = 2'b00;
    chk("xram_rd_o", 1, xram_rd);
    // Random byte programs; pass 3 revisits the first cell to test merging
    for (int i = 0; i < 6; i++) begin
      a = (i == 3) ? a0 : rnd_addr();
      if (i == 0) a0 = a;
      d = 8'($random(seed));
      prog(a, d);
      chk("fl_wdata_o", exp_prog(shadow[a], d), fl_wdata);
      chk("busy end", 0, busy);
      chk("prog cycles", 1, n >= PROG && n <= PROG + 2);
      shadow[a] = exp_prog(shadow[a], d);
      tick();
      chk("array", shadow[a], u_array.mem[a]);
    end
    n_byte = n;
    // Page erase from another address in the first cell's page
    program_store_erase_enable = 1'b1;
    fw(a0 ^ 15'h0155, 8'($random(seed)));
    program_store_erase_enable = 1'b0;
    chk("busy", 1, busy);
    wait_op(ERASE + 4);
    chk("erase", {1'b1, a0[14:10], 10'h0}, {fl_erase, fl_addr});
    chk("erase cycles", 1, n >= ERASE && n <= ERASE + 2);
    tick();
    chk("array", 8'hff, u_array.mem[a0]);
    for (int j = 0; j < 1024; j++) shadow[{a0[14:10], 10'(j)}] = 8'hff;
    // Block: one full block, then one cut short by deselecting block mode
    blk = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k % 4 == 0) a = rnd_addr() & 15'h7ffc;
      if (k == 7) begin
        blk = 1'b0;
        tick();
        blk = 1'b1;
      end
      // Byte 01 is all ones so that cell keeps its old value
      d = (k % 4 == 1) ? 8'hff : 8'($random(seed));
      blkd[k % 4] = d;
      fw(a + AW'(k % 4), d);
      wait_op(k == 3 ? ERASE + 4 : PROG + 3);
      chk("fl_wr_o", k == 3, fl_wr);
      if (k == 3) chk("block cycles", n_byte, n);
      // Staged bytes leave in address order, one every second cycle
      for (int j = 0; j < 4 && k == 3; j++) begin
        if (j > 0) repeat (2) tick();
        chk("block write", {1'b1, a + AW'(j),
          exp_prog(shadow[a + AW'(j)], blkd[j])},
          {fl_wr, fl_addr, fl_wdata});
        shadow[a + AW'(j)] = exp_prog(shadow[a + AW'(j)], blkd[j]);
      end
    end
    blk = 1'b0;
    chk("partial block", 0, {err, fl_wr});
    // A spent key refuses a bare write
    mw(rnd_addr(), 8'h00);
    wait_op(PROG + 3);
    chk("spent key", 2'b10, {err, fl_wr});
    reset_dut(8'hfd);
    // Locked pages: open to protected code, dropped from the debug port
    prot = 1'b1;
    prog({5'h01, 10'($random(seed))}, 8'h00);
    {prot, dbg} = 2'b01;
    fw({5'h1e, 10'h155}, 8'h00);
    wait_op(PROG + 3);
    chk("debug on lock page", 0, {err, fl_wr});
    dbg = 1'b0;
    reset_dut(8'hfd);
    fw({5'h00, 10'($random(seed))}, 8'h00);
    wait_op(PROG + 3);
    chk("locked page", 2'b10, {err, fl_wr});
    reset_dut(8'hff);
    prog({5'h1e, 10'h155}, 8'h00);
    // Wrong first key, and the keys in reverse order
    for (int k = 0; k < 2; k++) begin
      reset_dut(8'hff);
      key(k ? 8'hf1 : 8'h5a);
      chk("key_disabled_o", 1, kdead);
      tick();
      fw(rnd_addr(), 8'h00);
      wait_op(PROG + 3);
      chk("fl_wr_o", 0, fl_wr);
    end
    reset_dut(8'hff);
    sup_ok = 1'b0;
    fw(rnd_addr(), 8'h00);
    wait_op(PROG + 3);
    chk("supply off", 2'b10, {err, fl_wr});
    give_verdict();
  end
endmodule : flash_program_erase_control_test
`default_nettype wire
